// file: rtl/serial_port_config_consts.svh
// Offsets, field positions, reset values and timing counts of the serial port configuration bank.
// Assumes inclusion by bare name from rtl/ and verif/ files.
`ifndef SERIAL_PORT_CONFIG_CONSTS_SVH
`define SERIAL_PORT_CONFIG_CONSTS_SVH
`define SPC_ADDR_W 10
`define SPC_OFS_SETUP 10'h000
`define SPC_OFS_VARIANT 10'h003
`define SPC_OFS_READBACK 10'h004
`define SPC_OFS_TAG_LO 10'h005
`define SPC_OFS_TAG_HI 10'h006
`define SPC_BIT_SEP_OUT 7
`define SPC_BIT_LSB_FIRST 6
`define SPC_BIT_SOFT_RST 5
`define SPC_BIT_BANK_SEL 0
`define SPC_SETUP_RST 8'h00
`define SPC_READBACK_RST 8'h00
`define SPC_TAG_RST 8'h00
`define SPC_VARIANT_DEF 8'h5a
`define SPC_RELOAD_CYC 4'h4
`endif

// file: rtl/serial_port_config_pkg.sv
// Types shared by the serial port configuration bank.
// Assumes the consts header sits beside it.
package serial_port_config_pkg;
	// Soft reset sequencer states, one-hot
	typedef enum logic [2:0]
	{
		SR_IDLE = 3'b001,
		SR_LOAD = 3'b010,
		SR_DONE = 3'b100
	} soft_reset_e;
	// Reload source chosen at soft reset
	typedef enum logic
	{
		SRC_DEFAULTS = 1'b0,
		SRC_EEPROM = 1'b1
	} reload_src_e;
endpackage

// file: rtl/soft_reset_seq.sv
// Soft reset sequencer: holds the reload request for a fixed number of cycles.
// Assumes a single clock and synchronous active high reset.
`timescale 1ns/10ps
`include "serial_port_config_consts.svh"
module soft_reset_seq
	import serial_port_config_pkg::*;
#(
	parameter logic [3:0] LOAD_CYC = `SPC_RELOAD_CYC
)
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic start_in,
	output logic busy_out,
	output logic done_out
);
	// All state in one struct
	typedef struct packed
	{
		soft_reset_e st;
		logic [3:0] cnt;
	} seq_s;
	seq_s s_q;
	seq_s s_d;
	// Next state
	always_comb
	begin
		s_d = s_q;
		unique case (s_q.st)
			SR_IDLE:
			begin
				// Start the load window
				if (start_in)
				begin
					s_d.st = SR_LOAD;
					s_d.cnt = LOAD_CYC;
				end
			end
			SR_LOAD:
			begin
				// Count down the load window
				if (s_q.cnt == 4'h1)
					s_d.st = SR_DONE;
				else
					s_d.cnt = s_q.cnt - 4'h1;
			end
			SR_DONE:
				s_d.st = SR_IDLE;
			default:
				s_d.st = SR_IDLE;
		endcase
	end
	// Register state
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			s_q.st <= SR_IDLE;
			s_q.cnt <= 4'h0;
		end
		else
			s_q <= s_d;
	end
	assign busy_out = (s_q.st != SR_IDLE);
	assign done_out = (s_q.st == SR_DONE);
	// Load window lasts exactly four cycles, the default count
	a_load_length: assert property (@(posedge mclk_in) disable iff (rst_in)
		(s_q.st == SR_IDLE && start_in) |=> (s_q.st == SR_LOAD)[*4] ##1 done_out)
		else $error("Soft reset load window wrong length");
endmodule

// file: rtl/serial_port_config_regs.sv
// Serial port configuration register bank: setup, variant id, readback select, customer tag.
// Assumes the serial framer turns transfers into one-cycle byte writes and combinational reads.
// How it works
// - Setup bit 7 picks separate output pin
// - Setup bit 6: LSB first, address increments
// - Bit order ignored in I2C mode
// - Soft reset self-clears, EEPROM pin reloads EEPROM
// - EEPROM pin low restores on-chip defaults
// - Read-only variant identifier at 0x003
// - Bank select bit chooses readback source
// - Customer tag bytes, writable, no effect
`timescale 1ns/10ps
`include "serial_port_config_consts.svh"
module serial_port_config_regs
	import serial_port_config_pkg::*;
#(
	parameter logic [7:0] VARIANT_ID = `SPC_VARIANT_DEF // Arbitrary value
)
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic i2c_mode_in,
	input wire logic eeprom_pin_in,
	input wire logic [`SPC_ADDR_W-1:0] addr_in,
	input wire logic wr_en_in,
	input wire logic [7:0] wr_data_in,
	input wire logic [7:0] rd_active_in,
	output logic [7:0] rd_data_out,
	output logic separate_output_enable_out,
	output logic lsb_first_out,
	output logic addr_incr_out,
	output logic read_active_out,
	output logic reload_busy_out,
	output logic reload_eeprom_out,
	output logic reload_defaults_out,
	output logic [15:0] customer_tag_out
);
	// All state in one struct
	typedef struct packed
	{
		logic sep_out;
		logic lsb_first;
		logic soft_rst;
		logic bank_sel;
		logic [7:0] tag_lo;
		logic [7:0] tag_hi;
		reload_src_e src;
	} regs_s;
	regs_s r_q;
	regs_s r_d;
	logic seq_busy; // Reload window open
	logic seq_done; // Last cycle of reload
	// Rebuild the setup byte, mirrored in the low nibble
	function automatic logic [7:0] setup_byte(input logic sep, input logic lsb, input logic rst);
		setup_byte = {sep, lsb, rst, 1'b0, 1'b0, rst, lsb, sep};
	endfunction
	// Reload sequencer
	soft_reset_seq #(
		.LOAD_CYC(`SPC_RELOAD_CYC)
	) soft_reset_seq_i (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.start_in(r_q.soft_rst && !seq_busy),
		.busy_out(seq_busy),
		.done_out(seq_done)
	);
	// Next register values
	always_comb
	begin
		r_d = r_q;
		// Start of reload latches source from pin
		if (r_q.soft_rst && !seq_busy)
			r_d.src = eeprom_pin_in ? SRC_EEPROM : SRC_DEFAULTS;
		if (seq_done)
		begin
			// Self-clear; defaults restored in both cases here, EEPROM then overwrites via bus
			r_d.sep_out = 1'b0;
			r_d.lsb_first = 1'b0;
			r_d.soft_rst = 1'b0;
			r_d.bank_sel = 1'b0;
			r_d.tag_lo = `SPC_TAG_RST;
			r_d.tag_hi = `SPC_TAG_RST;
		end
		else if (wr_en_in && !seq_busy)
		begin
			// Writes are refused while reloading
			unique case (addr_in)
				`SPC_OFS_SETUP:
				begin
					// Only upper nibble decoded, host mirrors low nibble
					r_d.sep_out = wr_data_in[`SPC_BIT_SEP_OUT];
					r_d.lsb_first = wr_data_in[`SPC_BIT_LSB_FIRST];
					r_d.soft_rst = wr_data_in[`SPC_BIT_SOFT_RST];
				end
				`SPC_OFS_READBACK:
					r_d.bank_sel = wr_data_in[`SPC_BIT_BANK_SEL];
				`SPC_OFS_TAG_LO:
					r_d.tag_lo = wr_data_in;
				`SPC_OFS_TAG_HI:
					r_d.tag_hi = wr_data_in;
				default:
				begin
					// Variant id and others: write ignored
				end
			endcase
		end
	end
	// Register all state
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			r_q.sep_out <= 1'b0;
			r_q.lsb_first <= 1'b0;
			r_q.soft_rst <= 1'b0;
			r_q.bank_sel <= 1'b0;
			r_q.tag_lo <= `SPC_TAG_RST;
			r_q.tag_hi <= `SPC_TAG_RST;
			r_q.src <= SRC_DEFAULTS;
		end
		else
			r_q <= r_d;
	end
	// Readback mux; bank select picks active copy for unmapped addresses, else zero
	always_comb
	begin
		rd_data_out = 8'h00;
		unique case (addr_in)
			`SPC_OFS_SETUP:
				rd_data_out = setup_byte(r_q.sep_out, r_q.lsb_first, r_q.soft_rst);
			`SPC_OFS_VARIANT:
				rd_data_out = VARIANT_ID;
			`SPC_OFS_READBACK:
				rd_data_out = {7'h00, r_q.bank_sel};
			`SPC_OFS_TAG_LO:
				rd_data_out = r_q.tag_lo;
			`SPC_OFS_TAG_HI:
				rd_data_out = r_q.tag_hi;
			default:
				rd_data_out = r_q.bank_sel ? rd_active_in : 8'h00;
		endcase
	end
	// Mode outputs; I2C forces MSB first and decrement
	assign separate_output_enable_out = r_q.sep_out;
	assign lsb_first_out = r_q.lsb_first && !i2c_mode_in;
	assign addr_incr_out = r_q.lsb_first && !i2c_mode_in;
	assign read_active_out = r_q.bank_sel;
	assign reload_busy_out = seq_busy;
	assign reload_eeprom_out = seq_done && (r_q.src == SRC_EEPROM);
	assign reload_defaults_out = seq_done && (r_q.src == SRC_DEFAULTS);
	assign customer_tag_out = {r_q.tag_hi, r_q.tag_lo};

	// Bit order must be masked in I2C framing, not merely unused
	a_i2c_order: assert property (@(posedge mclk_in) disable iff (rst_in)
		i2c_mode_in |-> !lsb_first_out && !addr_incr_out)
		else $error("Bit order active in I2C mode");

	// Identifier byte never moves, whatever was written to it
	a_variant_read: assert property (@(posedge mclk_in) disable iff (rst_in)
		(addr_in == `SPC_OFS_VARIANT) |-> rd_data_out == VARIANT_ID)
		else $error("Variant id wrong");

	// Host polls this bit, so it must drop within eight cycles of rising
	a_soft_selfclr: assert property (@(posedge mclk_in) disable iff (rst_in)
		$rose(r_q.soft_rst) |-> ##[1:8] !r_q.soft_rst)
		else $error("Soft reset did not clear");

	// Done cycle is the one that clears the request bit
	a_soft_done: assert property (@(posedge mclk_in) disable iff (rst_in)
		seq_done |=> !r_q.soft_rst)
		else $error("Soft reset bit kept after reload");

	// Start edge, four load edges, then the pulse is seen on the fifth
	a_src_eeprom: assert property (@(posedge mclk_in) disable iff (rst_in)
		(r_q.soft_rst && !seq_busy && eeprom_pin_in) |-> ##5 reload_eeprom_out)
		else $error("EEPROM reload missing");

	// Same timing with the source pin low
	a_src_default: assert property (@(posedge mclk_in) disable iff (rst_in)
		(r_q.soft_rst && !seq_busy && !eeprom_pin_in) |-> ##5 reload_defaults_out)
		else $error("Default reload missing");

	// Reload leaves every stored field except the latched source at its reset value
	a_reload_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
		(reload_eeprom_out || reload_defaults_out) |=> (customer_tag_out == 16'h0000
			&& !separate_output_enable_out && !r_q.lsb_first && !read_active_out))
		else $error("Registers not restored by reload");

	// Unused setup bit 4 and its mirror bit 3 read as zero
	a_setup_unused: assert property (@(posedge mclk_in) disable iff (rst_in)
		(addr_in == `SPC_OFS_SETUP) |-> rd_data_out[4:3] == 2'b00)
		else $error("Unused setup bits not zero");

	// Only bit 0 of the bank select byte exists
	a_bank_unused: assert property (@(posedge mclk_in) disable iff (rst_in)
		(addr_in == `SPC_OFS_READBACK) |-> rd_data_out[7:1] == 7'h00)
		else $error("Unused bits not zero");

	// Writes land only outside the reload window
	a_sep_write: assert property (@(posedge mclk_in) disable iff (rst_in)
		(wr_en_in && !seq_busy && !seq_done && addr_in == `SPC_OFS_SETUP)
		|=> separate_output_enable_out == $past(wr_data_in[7]))
		else $error("Pin mode not written");

	// Bit order field follows the written byte
	a_lsb_write: assert property (@(posedge mclk_in) disable iff (rst_in)
		(wr_en_in && !seq_busy && addr_in == `SPC_OFS_SETUP)
		|=> r_q.lsb_first == $past(wr_data_in[6]))
		else $error("Bit order not written");

	// Bank select follows the written byte
	a_bank_write: assert property (@(posedge mclk_in) disable iff (rst_in)
		(wr_en_in && !seq_busy && addr_in == `SPC_OFS_READBACK)
		|=> read_active_out == $past(wr_data_in[0]))
		else $error("Bank select not written");

	// Tag high byte is a plain store
	a_tag_write: assert property (@(posedge mclk_in) disable iff (rst_in)
		(wr_en_in && !seq_busy && !seq_done && addr_in == `SPC_OFS_TAG_HI)
		|=> customer_tag_out[15:8] == $past(wr_data_in))
		else $error("Tag high not written");

	// Tag low byte is a plain store too
	a_tag_lo_write: assert property (@(posedge mclk_in) disable iff (rst_in)
		(wr_en_in && !seq_busy && addr_in == `SPC_OFS_TAG_LO)
		|=> customer_tag_out[7:0] == $past(wr_data_in))
		else $error("Tag low not written");

	// Main scenarios the bench is expected to reach
	c_eeprom_reload: cover property (@(posedge mclk_in) reload_eeprom_out);
	c_default_reload: cover property (@(posedge mclk_in) reload_defaults_out);
	c_lsb_mode: cover property (@(posedge mclk_in) addr_incr_out);
	c_active_read: cover property (@(posedge mclk_in) read_active_out && addr_in == 10'h100);
	c_i2c_masked: cover property (@(posedge mclk_in) i2c_mode_in && r_q.lsb_first);
endmodule

// file: verif/host_model.sv
// Host controller model: byte writes and reads on the register port.
// Assumes the bench makes the clock; signals change just after a rising edge.
`timescale 1ns/10ps
module host_model
(
	input wire logic mclk_in,
	input wire logic [7:0] rd_data_in,
	output logic [9:0] addr_out,
	output logic wr_en_out,
	output logic [7:0] wr_data_out
);
	// Idle bus before the first request
	initial
	begin
		addr_out = 10'h3ff;
		wr_en_out = 1'b0;
		wr_data_out = 8'h00;
	end
	// One-cycle strobe; data is scrambled after release so it is not reused
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		addr_out <= a;
		wr_en_out <= 1'b1;
		wr_data_out <= d;
		@(posedge mclk_in);
		wr_en_out <= 1'b0;
		wr_data_out <= ~d;
	endtask
	// Setup write, low nibble mirrors the high one
	task automatic ws(input logic [3:0] h);
		wr(10'h000, {h, h[0], h[1], h[2], h[3]});
	endtask
	// Reads are combinational, sampled mid-cycle
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge mclk_in);
		addr_out <= a;
		@(negedge mclk_in);
		d = rd_data_in;
	endtask
endmodule

// file: verif/tb.sv
// Self-checking bench for the serial port configuration bank.
// Assumes the consts header is on the include path.
`timescale 1ns/10ps
`include "serial_port_config_consts.svh"
module tb;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic i2c = 1'b0;
	logic eep = 1'b0;
	logic [7:0] act = 8'h00; // Active bank byte from the rest of the chip
	logic [9:0] addr;
	logic wr_en;
	logic [7:0] wdat, rdat;
	logic sep, lsb, incr, ract, busy, r_eep, r_def;
	logic [15:0] tag;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	always #10 mclk_in = ~mclk_in;
	serial_port_config_regs serial_port_config_regs_i (.mclk_in(mclk_in), .rst_in(rst_in), .i2c_mode_in(i2c),
		.eeprom_pin_in(eep), .addr_in(addr), .wr_en_in(wr_en), .wr_data_in(wdat), .rd_active_in(act),
		.rd_data_out(rdat), .separate_output_enable_out(sep), .lsb_first_out(lsb), .addr_incr_out(incr),
		.read_active_out(ract), .reload_busy_out(busy), .reload_eeprom_out(r_eep),
		.reload_defaults_out(r_def), .customer_tag_out(tag));
	host_model host_model_i (.mclk_in(mclk_in), .rd_data_in(rdat), .addr_out(addr), .wr_en_out(wr_en),
		.wr_data_out(wdat));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Read one address and compare
	task automatic rc(input logic [9:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host_model_i.rd(a, d);
		chk(d, exp);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Hang guard, far above the hundred or fewer cycles needed
	always @(posedge mclk_in)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			wrap_up();
		end
	end
	// Values straight after reset
	task automatic t_reset;
		rc(10'h000, 8'h00);
		rc(10'h003, `SPC_VARIANT_DEF);
		rc(10'h004, 8'h00);
		rc(10'h005, 8'h00);
		rc(10'h006, 8'h00);
	endtask
	// Pin mode, bit order, and I2C masking of bit order
	task automatic t_setup;
		host_model_i.ws(4'h8);
		rc(10'h000, 8'h81);
		chk({sep, lsb, incr}, 3'b100);
		host_model_i.ws(4'h4);
		rc(10'h000, 8'h42);
		chk({sep, lsb, incr}, 3'b011);
		@(posedge mclk_in);
		i2c <= 1'b1;
		@(negedge mclk_in);
		chk({lsb, incr}, 2'b00);
		@(posedge mclk_in);
		i2c <= 1'b0;
	endtask
	// Read-only id, bank select, unused bits and unmapped readback
	task automatic t_bank;
		host_model_i.wr(10'h000, 8'h1f);
		rc(10'h000, 8'h00);
		host_model_i.wr(10'h003, 8'hff);
		rc(10'h003, `SPC_VARIANT_DEF);
		@(posedge mclk_in);
		act <= 8'hc3;
		rc(10'h100, 8'h00);
		host_model_i.wr(10'h004, 8'hff);
		rc(10'h004, 8'h01);
		chk(ract, 1'b1);
		rc(10'h100, 8'hc3);
	endtask
	// Tag bytes land in the right halves
	task automatic t_tag;
		host_model_i.wr(10'h005, 8'h34);
		host_model_i.wr(10'h006, 8'h12);
		@(negedge mclk_in);
		chk(tag, 16'h1234);
		rc(10'h006, 8'h12);
	endtask
	// Soft reset by pin; counts busy cycles and both pulses
	task automatic t_reload(input logic pin);
		int nb, ne, nd;
		nb = 0;
		ne = 0;
		nd = 0;
		@(posedge mclk_in);
		eep <= pin;
		host_model_i.ws(4'h2);
		repeat (12)
		begin
			@(negedge mclk_in);
			nb += (busy === 1'b1);
			ne += (r_eep === 1'b1);
			nd += (r_def === 1'b1);
		end
		chk(nb, 5);
		chk({ne[3:0], nd[3:0]}, pin ? 8'h10 : 8'h01);
		rc(10'h000, 8'h00);
		rc(10'h004, 8'h00);
		chk(tag, 16'h0000);
	endtask
	initial
	begin
		repeat (8) @(posedge mclk_in);
		rst_in <= 1'b0;
		t_reset();
		t_setup();
		t_bank();
		t_tag();
		t_reload(1'b1);
		t_tag();
		t_reload(1'b0);
		wrap_up();
	end
endmodule
